// ---- logic/rcr_pkg.sv ----
// Package with register map, field layouts, reset values and timing for the reset controller.
package rcr_pkg;

	// Register indices as printed, byte address is four times the index.
	localparam logic [7:0] RCR_PCL_IDX = 8'h02;
	localparam logic [7:0] RCR_STATUS_IDX = 8'h03;
	localparam logic [7:0] RCR_CTRL_IDX = 8'h04;
	localparam logic [7:0] RCR_CAUSE_IDX = 8'h05;
	localparam logic [7:0] RCR_WREG_IDX = 8'h06;

	// Status register field layout.
	typedef struct packed {
		logic pin_change_wake_flag;
		logic [1:0] page_bits;
		logic timeout_flag_n;
		logic powerdown_flag_n;
		logic [2:0] low_bits;
	} rcr_status_t;

	// Control register field layout.
	typedef struct packed {
		logic [5:0] unused;
		logic osc_crystal;
		logic reset_pin_enable;
	} rcr_ctrl_t;

	// Reset values.
	localparam rcr_status_t RCR_STATUS_POR = 8'h18;
	localparam logic [7:0] RCR_PCL_RESET = 8'hFF;
	localparam logic [7:0] RCR_PC_WRAP = 8'h00;
	localparam rcr_ctrl_t RCR_CTRL_RESET = 8'h01;

	// Reset causes, one-hot, as read back from the cause register.
	typedef enum logic [5:0] {
		RCR_CAUSE_POR = 6'h01,
		RCR_CAUSE_EXT_RUN = 6'h02,
		RCR_CAUSE_EXT_SLEEP = 6'h04,
		RCR_CAUSE_WDT_RUN = 6'h08,
		RCR_CAUSE_WDT_SLEEP = 6'h10,
		RCR_CAUSE_WAKE = 6'h20
	} rcr_cause_t;

	// Sequencer states, one-hot.
	typedef enum logic [3:0] {
		RCR_ST_HOLD = 4'h1,
		RCR_ST_TIMING = 4'h2,
		RCR_ST_VECTOR = 4'h4,
		RCR_ST_RUN = 4'h8
	} rcr_state_t;

	// Timing: clock period and reset timer periods in their own units.
	localparam int RCR_CLK_PERIOD_NS = 100;
	localparam int RCR_DRT_LONG_MS = 18;
	localparam int RCR_DRT_SHORT_US = 300;
	localparam int RCR_DRT_LONG_CYC = RCR_DRT_LONG_MS * 1000000 / RCR_CLK_PERIOD_NS;
	localparam int RCR_DRT_SHORT_CYC = RCR_DRT_SHORT_US * 1000 / RCR_CLK_PERIOD_NS;
	localparam int RCR_DRT_W = 18;

	// Bus responses.
	localparam logic [1:0] RCR_RESP_OKAY = 2'h0;
	localparam logic [1:0] RCR_RESP_SLVERR = 2'h2;

endpackage

// ---- logic/rcr_reset_ctrl.sv ----
// Reset cause detection, reset latch with device reset timer, and AXI4-Lite register slave.
//
// Operation
// - Six reset causes told apart: power-on, pin run/sleep, watchdog run/sleep, wake.
// - Registers without reset keep contents across every cause except power-on.
// - Resettable registers load reset state on power-on, pin run, watchdog run, wake.
// - Pin or watchdog reset while asleep resumes; only status bits, program counter and working register bits 7:2 change.
// - Timeout, powerdown and wake flags set per cause so software can identify it.
// - Power-on status reads wake 0, bits 6:5 clear, timeout 1, powerdown 1.
// - Pin reset while running clears wake and bits 6:5, keeps the rest.
// - Pin reset asleep clears wake, bits 6:5, sets timeout, clears powerdown.
// - Watchdog reset asleep clears wake, bits 6:5, timeout and powerdown.
// - Watchdog reset running clears wake, bits 6:5 and timeout, keeps powerdown.
// - Wake reset sets wake, clears bits 6:5, sets timeout, clears powerdown.
// - Program counter low byte loads all ones for every reset cause.
// - Working register bits 7:2 hold the trim value after reset.
// - Reset-pin enable at 1 makes pin the reset; at 0 pin is plain input.
// - Pin pull-up stays enabled whenever the pin is the reset input.
// - Power-on reset holds the chip in reset until supply is adequate.
// - At power-up the reset latch sets and the reset timer clears.
// - Reset timer counts only while the external reset input is high.
// - Reset timer expiry clears the latch, releasing on-chip reset.
// - After the vector instruction the program counter wraps to zero.
// - Timer period long after power-on; later resets short for RC, long for crystal.
// - Active-low timeout flag at status bit 4 clears on watchdog reset.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module rcr_reset_ctrl
	import rcr_pkg::*;
#(
	parameter int DRT_LONG_CYCLES = RCR_DRT_LONG_CYC
) (
	// Clock and power-on reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data.
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response.
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read.
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Shared reset or port pin.
	input wire logic shared_reset_port_pin,
	output logic pin_pullup_en,
	output logic gpio_level,
	// Events from the core and watchdog.
	input wire logic watchdog_timeout,
	input wire logic pin_change_wake,
	input wire logic sleep_enter,
	input wire logic [5:0] oscillator_trim,
	// Reset outputs to the core.
	output logic chip_reset,
	output logic regs_reset,
	output logic asleep
);

	// Pin synchroniser; the first stage is read only by the second.
	logic pin_s1_q;
	logic pin_s2_q;
	logic pin_s3_q;
	logic pin_level_q;
	rcr_ctrl_t ctrl_q;
	logic external_reset_input;
	logic ext_low;

	always_ff @(posedge aclk) begin
		pin_s1_q <= shared_reset_port_pin;
		pin_s2_q <= pin_s1_q;
		pin_s3_q <= pin_s2_q;
	end

	// A change counts once the two later stages agree; idle level is high.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_level_q <= 1'b1;
		end else if (pin_s2_q == pin_s3_q) begin
			pin_level_q <= pin_s3_q;
		end
	end

	// With the pin function disabled the internal reset input is tied high.
	assign external_reset_input = ctrl_q.reset_pin_enable ? pin_level_q : 1'b1;
	assign ext_low = !external_reset_input;

	// Pin-side outputs: pull-up follows the reset function, port level otherwise.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_pullup_en <= 1'b1;
			gpio_level <= 1'b1;
		end else begin
			pin_pullup_en <= ctrl_q.reset_pin_enable;
			gpio_level <= ctrl_q.reset_pin_enable ? 1'b1 : pin_level_q;
		end
	end

	// Sequencer and reset timer state.
	rcr_state_t state_q;
	logic [RCR_DRT_W-1:0] drt_q;
	logic [RCR_DRT_W-1:0] drt_limit;
	logic por_pending_q;
	logic asleep_q;
	logic new_cause;
	rcr_cause_t cause_d;
	rcr_cause_t cause_q;

	// Cause priority: pin, then watchdog, then wake; only a running or sleeping core sees them.
	always_comb begin
		new_cause = 1'b0;
		cause_d = cause_q;
		if (state_q == RCR_ST_RUN) begin
			if (ext_low) begin
				new_cause = 1'b1;
				cause_d = asleep_q ? RCR_CAUSE_EXT_SLEEP : RCR_CAUSE_EXT_RUN;
			end else if (watchdog_timeout) begin
				new_cause = 1'b1;
				cause_d = asleep_q ? RCR_CAUSE_WDT_SLEEP : RCR_CAUSE_WDT_RUN;
			end else if (pin_change_wake && asleep_q) begin
				new_cause = 1'b1;
				cause_d = RCR_CAUSE_WAKE;
			end
		end
	end

	// Period: long after power-on, then per oscillator type.
	always_comb begin
		if (por_pending_q || ctrl_q.osc_crystal) begin
			drt_limit = DRT_LONG_CYCLES[RCR_DRT_W-1:0];
		end else begin
			drt_limit = RCR_DRT_SHORT_CYC[RCR_DRT_W-1:0];
		end
	end

	// Sequencer: hold, count while the reset input is high, one vector cycle, run.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= RCR_ST_HOLD;
			drt_q <= '0;
		end else begin
			case (state_q)
				RCR_ST_HOLD: begin
					drt_q <= '0;
					if (external_reset_input) begin
						state_q <= RCR_ST_TIMING;
					end
				end
				RCR_ST_TIMING: begin
					if (ext_low) begin
						// A new low pulse restarts the full timer period.
						state_q <= RCR_ST_HOLD;
						drt_q <= '0;
					end else if (drt_q == drt_limit - 1'b1) begin
						state_q <= RCR_ST_VECTOR;
						drt_q <= '0;
					end else begin
						drt_q <= drt_q + 1'b1;
					end
				end
				RCR_ST_VECTOR: begin
					state_q <= RCR_ST_RUN;
				end
				RCR_ST_RUN: begin
					if (new_cause) begin
						state_q <= RCR_ST_HOLD;
					end
				end
				default: begin
					state_q <= RCR_ST_HOLD;
					drt_q <= '0;
				end
			endcase
		end
	end

	// The long power-on period applies until the first release.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_pending_q <= 1'b1;
		end else if (state_q == RCR_ST_VECTOR) begin
			por_pending_q <= 1'b0;
		end
	end

	// Cause record and sleep state; any reset ends sleep.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cause_q <= RCR_CAUSE_POR;
			asleep_q <= 1'b0;
		end else if (new_cause) begin
			cause_q <= cause_d;
			asleep_q <= 1'b0;
		end else if (sleep_enter && state_q == RCR_ST_RUN) begin
			asleep_q <= 1'b1;
		end
	end

	// Reset outputs come from flops; the release lands on a clock edge.
	logic regs_load_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chip_reset <= 1'b1;
			regs_load_q <= 1'b1;
		end else if (new_cause) begin
			chip_reset <= 1'b1;
			// Sleep resets resume operation and leave ordinary registers alone.
			regs_load_q <= (cause_d == RCR_CAUSE_EXT_RUN) || (cause_d == RCR_CAUSE_WDT_RUN)
				|| (cause_d == RCR_CAUSE_WAKE);
		end else if (state_q == RCR_ST_TIMING && ext_low == 1'b0 && drt_q == drt_limit - 1'b1) begin
			chip_reset <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			regs_reset <= 1'b1;
			asleep <= 1'b0;
		end else begin
			regs_reset <= regs_load_q && (state_q != RCR_ST_RUN) && (state_q != RCR_ST_VECTOR);
			asleep <= asleep_q;
		end
	end

	// AXI4-Lite write channel: address and data in either order, response after both.
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] wr_idx_q;
	logic [7:0] wr_byte_q;
	logic wr_lane_q;
	logic do_write;
	logic wr_hit;

	assign do_write = aw_have_q && w_have_q && !bvalid;
	assign wr_hit = (wr_idx_q == RCR_PCL_IDX) || (wr_idx_q == RCR_STATUS_IDX)
		|| (wr_idx_q == RCR_CTRL_IDX) || (wr_idx_q == RCR_WREG_IDX);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			wr_idx_q <= '0;
			wr_byte_q <= '0;
			wr_lane_q <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RCR_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_have_q <= 1'b1;
				awready <= 1'b0;
				// Upper address bits above the map must be zero for a hit.
				wr_idx_q <= (awaddr[31:10] == '0) ? awaddr[9:2] : 8'hFF;
			end
			if (wvalid && wready) begin
				w_have_q <= 1'b1;
				wready <= 1'b0;
				wr_byte_q <= wdata[7:0];
				wr_lane_q <= wstrb[0];
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= wr_hit ? RCR_RESP_OKAY : RCR_RESP_SLVERR;
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// A software write counts only while the core runs and byte lane 0 is strobed.
	logic sw_wr;
	assign sw_wr = do_write && wr_lane_q && (state_q == RCR_ST_RUN);

	// Control register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= RCR_CTRL_RESET;
		end else if (sw_wr && wr_idx_q == RCR_CTRL_IDX) begin
			ctrl_q <= {6'h00, wr_byte_q[1:0]};
		end
	end

	// Status register: cause flags per reset, software owns bits 7:5 and 2:0.
	rcr_status_t status_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Low bits are undefined after power-on; they settle at zero here.
			status_q <= RCR_STATUS_POR;
		end else if (new_cause) begin
			// Bits 6:5 clear on every cause, the wake flag on every cause except wake; low bits kept.
			status_q.pin_change_wake_flag <= (cause_d == RCR_CAUSE_WAKE);
			status_q.page_bits <= 2'h0;
			case (cause_d)
				RCR_CAUSE_EXT_SLEEP: begin
					status_q.timeout_flag_n <= 1'b1;
					status_q.powerdown_flag_n <= 1'b0;
				end
				RCR_CAUSE_WDT_SLEEP: begin
					status_q.timeout_flag_n <= 1'b0;
					status_q.powerdown_flag_n <= 1'b0;
				end
				RCR_CAUSE_WDT_RUN: begin
					status_q.timeout_flag_n <= 1'b0;
				end
				RCR_CAUSE_WAKE: begin
					status_q.timeout_flag_n <= 1'b1;
					status_q.powerdown_flag_n <= 1'b0;
				end
				default: begin
					// Pin reset while running leaves both flags as they were.
					status_q.timeout_flag_n <= status_q.timeout_flag_n;
				end
			endcase
		end else if (sleep_enter && state_q == RCR_ST_RUN) begin
			status_q.timeout_flag_n <= 1'b1;
			status_q.powerdown_flag_n <= 1'b0;
		end else if (sw_wr && wr_idx_q == RCR_STATUS_IDX) begin
			// Timeout and powerdown flags are read-only to software; the wake flag at bit 7 is writable.
			status_q.pin_change_wake_flag <= wr_byte_q[7];
			status_q.page_bits <= wr_byte_q[6:5];
			status_q.low_bits <= wr_byte_q[2:0];
		end
	end

	// Program counter low byte: all ones in reset, wraps to zero after the vector.
	logic [7:0] pcl_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pcl_q <= RCR_PCL_RESET;
		end else if (new_cause) begin
			pcl_q <= RCR_PCL_RESET;
		end else if (state_q == RCR_ST_VECTOR) begin
			pcl_q <= RCR_PC_WRAP;
		end else if (sw_wr && wr_idx_q == RCR_PCL_IDX) begin
			pcl_q <= wr_byte_q;
		end
	end

	// Working register: the vector instruction loads the trim into bits 7:2.
	logic [7:0] wreg_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wreg_q <= 8'h00;
		end else if (state_q == RCR_ST_VECTOR) begin
			wreg_q[7:2] <= oscillator_trim;
		end else if (sw_wr && wr_idx_q == RCR_WREG_IDX) begin
			wreg_q <= wr_byte_q;
		end
	end

	// AXI4-Lite read channel: one read at a time, data registered with rvalid.
	logic [7:0] rd_idx;
	logic [7:0] rd_byte;
	logic rd_hit;

	assign rd_idx = araddr[9:2];

	always_comb begin
		rd_hit = (araddr[31:10] == '0);
		rd_byte = 8'h00;
		case (rd_idx)
			RCR_PCL_IDX: rd_byte = pcl_q;
			RCR_STATUS_IDX: rd_byte = status_q;
			RCR_CTRL_IDX: rd_byte = ctrl_q;
			RCR_CAUSE_IDX: rd_byte = {2'h0, cause_q};
			RCR_WREG_IDX: rd_byte = wreg_q;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RCR_RESP_OKAY;
		end else begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= {24'h000000, rd_byte};
				rresp <= rd_hit ? RCR_RESP_OKAY : RCR_RESP_SLVERR;
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

endmodule

// ---- dv/rcr_reset_ctrl_asserts.sv ----
// Concurrent checks on the reset controller ports, bound into the design.
`timescale 1ns/10ps
module rcr_reset_ctrl_asserts
	import rcr_pkg::*;
#(
	parameter int DRT_LONG_CYCLES = RCR_DRT_LONG_CYC
) (
	// Clock and power-on reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes.
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// Events and pin.
	input wire logic watchdog_timeout,
	input wire logic pin_change_wake,
	input wire logic sleep_enter,
	input wire logic pin_pullup_en,
	input wire logic gpio_level,
	// Reset outputs.
	input wire logic chip_reset,
	input wire logic regs_reset,
	input wire logic asleep
);
	localparam int SHORT = RCR_DRT_SHORT_CYC;
	localparam int MIN_HOLD = (DRT_LONG_CYCLES < SHORT) ? DRT_LONG_CYCLES : SHORT;
	logic [31:0] hold_q;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Length of the current reset hold; an early release is invisible without it.
	always_ff @(posedge aclk) begin
		if (!aresetn || !chip_reset) begin
			hold_q <= 32'h0;
		end else begin
			hold_q <= hold_q + 32'h1;
		end
	end

	// Settled running state, so the vector step is never mistaken for run.
	sequence s_running;
		(!chip_reset && !regs_reset)[*3];
	endsequence

	a_por_holds: assert property ($rose(aresetn) |-> (chip_reset && regs_reset)[*4])
		else $error("chip reset not held after power-on");
	a_hold_min: assert property ($fell(chip_reset) |-> hold_q >= 32'(MIN_HOLD))
		else $error("reset released before timer period");
	a_wdt_resets: assert property (s_running ##0 watchdog_timeout |=> chip_reset)
		else $error("watchdog expiry did not reset");
	a_sleep_enters: assert property (s_running ##0 (sleep_enter && !watchdog_timeout
		&& !pin_change_wake) |-> ##2 asleep)
		else $error("sleep not entered");
	a_sleep_keeps: assert property (asleep && watchdog_timeout && !chip_reset
		|=> chip_reset && !regs_reset)
		else $error("sleep watchdog reset reloaded registers");
	a_wake_reloads: assert property (asleep && pin_change_wake && !watchdog_timeout
		&& !chip_reset |=> chip_reset ##1 regs_reset)
		else $error("wake reset did not reload registers");
	a_pullup_gpio: assert property (pin_pullup_en |-> gpio_level)
		else $error("gpio level not idle while pin is reset");
	a_gpio_no_reset: assert property (s_running ##0 (!pin_pullup_en && !$past(pin_pullup_en, 4)
		&& !watchdog_timeout && !pin_change_wake) |=> !chip_reset)
		else $error("pin reset while pin is general input");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write response missing");
	a_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h0)
		else $error("read answer late or wide");
endmodule

bind rcr_reset_ctrl rcr_reset_ctrl_asserts #(.DRT_LONG_CYCLES(DRT_LONG_CYCLES)) i_asserts (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
	.watchdog_timeout(watchdog_timeout), .pin_change_wake(pin_change_wake),
	.sleep_enter(sleep_enter), .pin_pullup_en(pin_pullup_en), .gpio_level(gpio_level),
	.chip_reset(chip_reset), .regs_reset(regs_reset), .asleep(asleep)
);

// ---- dv/testbench.sv ----
// Self-checking bench for the reset controller.
`timescale 1ns/10ps
module testbench
	import rcr_pkg::*;
#(
	parameter int DEVICE_RESET_TIMER = 50
);
	localparam logic [5:0] TRIM = 6'h2D;
	localparam logic [31:0] A_PCL = {22'h0, RCR_PCL_IDX, 2'h0};
	localparam logic [31:0] A_ST = {22'h0, RCR_STATUS_IDX, 2'h0};
	localparam logic [31:0] A_CT = {22'h0, RCR_CTRL_IDX, 2'h0};
	localparam logic [31:0] A_CS = {22'h0, RCR_CAUSE_IDX, 2'h0};
	localparam logic [31:0] A_WR = {22'h0, RCR_WREG_IDX, 2'h0};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic watchdog_timeout = 1'b0, pin_change_wake = 1'b0, sleep_enter = 1'b0;
	logic shared_reset_port_pin = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, pin_pullup_en, gpio_level;
	logic chip_reset, regs_reset, asleep;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int mismatches = 0;
	int tests_run = 0;
	int cyc = 0;

	// Clock and a free cycle count for measuring reset holds.
	always #50 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;

	// Short timer parameter keeps the crystal and power-on holds quick.
	rcr_reset_ctrl #(.DRT_LONG_CYCLES(DEVICE_RESET_TIMER)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .shared_reset_port_pin(shared_reset_port_pin),
		.pin_pullup_en(pin_pullup_en), .gpio_level(gpio_level),
		.watchdog_timeout(watchdog_timeout), .pin_change_wake(pin_change_wake),
		.sleep_enter(sleep_enter), .oscillator_trim(TRIM), .chip_reset(chip_reset),
		.regs_reset(regs_reset), .asleep(asleep)
	);

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rng(input string nm, input int v, input int lo);
		tests_run++;
		if (v < lo || v > lo + 10) begin
			mismatches++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, lo + 10, v);
		end
	endtask

	// Address and data go out together; each is dropped once its own ready is seen.
	task automatic axi_wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		// A missing answer counts as a mismatch rather than passing silently.
		if (bvalid !== 1'b1) mismatches++;
		bready <= 1'b0;
		chk("bresp", {6'h0, er}, {6'h0, bresp});
		// One idle edge keeps a following call from reassigning bready at once.
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [31:0] a, output logic [7:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 100);
		if (rvalid !== 1'b1) mismatches++;
		d = rdata[7:0];
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [7:0] e, input string nm);
		logic [7:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk(nm, e, d);
		chk("rresp", 8'h0, {6'h0, r});
	endtask

	// One-cycle event pulse: bit 2 wake, bit 1 watchdog, bit 0 sleep.
	task automatic ev(input logic [2:0] k);
		{pin_change_wake, watchdog_timeout, sleep_enter} <= k;
		@(posedge aclk);
		{pin_change_wake, watchdog_timeout, sleep_enter} <= 3'h0;
	endtask

	task automatic wait_rel(input int t0, output int per);
		int n;
		n = 0;
		while (chip_reset !== 1'b0 && n < 4000) begin
			@(posedge aclk);
			n++;
		end
		if (chip_reset !== 1'b0) mismatches++;
		per = cyc - t0;
		repeat (4) @(posedge aclk);
	endtask

	// Fires one cause (zero means the pin), then checks the flags and the release.
	task automatic do_reset(input logic [2:0] k, input logic [7:0] st, input logic [7:0] cs,
		input logic rr, output int per);
		int t0;
		int n;
		t0 = cyc;
		n = 0;
		if (k == 3'h0) shared_reset_port_pin <= 1'b0;
		else ev(k);
		while (chip_reset !== 1'b1 && n < 20) begin
			@(posedge aclk);
			n++;
		end
		shared_reset_port_pin <= 1'b1;
		@(posedge aclk);
		chk("regs_reset", {7'h0, rr}, {7'h0, regs_reset});
		rd_chk(A_PCL, 8'hFF, "pcl in reset");
		rd_chk(A_ST, st, "status");
		rd_chk(A_CS, cs, "cause");
		wait_rel(t0, per);
		rd_chk(A_PCL, 8'h00, "pcl wrap");
		chk("asleep", 8'h0, {7'h0, asleep});
	endtask

	task automatic t_por;
		int per;
		repeat (20) @(posedge aclk);
		chk("held in reset", 8'h1, {7'h0, chip_reset});
		axi_wr(A_PCL, 8'h33, RCR_RESP_OKAY);
		rd_chk(A_PCL, 8'hFF, "pcl at power-on");
		rd_chk(A_ST, RCR_STATUS_POR, "status at power-on");
		shared_reset_port_pin <= 1'b1;
		wait_rel(cyc, per);
		rng("power-on period", per, DEVICE_RESET_TIMER);
		rd_chk(A_PCL, 8'h00, "pcl wrap");
		rd_chk(A_WR, {TRIM, 2'h0}, "work reg");
		rd_chk(A_CS, RCR_CAUSE_POR, "cause");
		rd_chk(A_CT, RCR_CTRL_RESET, "ctrl");
		chk("pullup", 8'h1, {7'h0, pin_pullup_en});
		$display("power-on test done");
	endtask

	task automatic t_wdt_run;
		int per;
		axi_wr(A_ST, 8'hE5, RCR_RESP_OKAY);
		rd_chk(A_ST, 8'hFD, "flags read-only");
		axi_wr(A_WR, 8'hAB, RCR_RESP_OKAY);
		do_reset(3'h2, 8'h0D, RCR_CAUSE_WDT_RUN, 1'b1, per);
		rng("short period", per, RCR_DRT_SHORT_CYC);
		rd_chk(A_WR, {TRIM, 2'h3}, "work reg low bits");
		$display("watchdog run test done");
	endtask

	task automatic t_pin_run;
		int per;
		axi_wr(A_ST, 8'hE5, RCR_RESP_OKAY);
		do_reset(3'h0, 8'h0D, RCR_CAUSE_EXT_RUN, 1'b1, per);
		$display("pin run test done");
	endtask

	task automatic t_sleep_pin;
		int per;
		axi_wr(A_ST, 8'hE5, RCR_RESP_OKAY);
		ev(3'h1);
		// The sleep level is registered twice before it shows on the port.
		repeat (2) @(posedge aclk);
		chk("asleep", 8'h1, {7'h0, asleep});
		do_reset(3'h0, 8'h15, RCR_CAUSE_EXT_SLEEP, 1'b0, per);
		$display("pin sleep test done");
	endtask

	task automatic t_sleep_wdt;
		int per;
		axi_wr(A_CT, 8'h03, RCR_RESP_OKAY);
		axi_wr(A_ST, 8'hE5, RCR_RESP_OKAY);
		ev(3'h1);
		@(posedge aclk);
		do_reset(3'h2, 8'h05, RCR_CAUSE_WDT_SLEEP, 1'b0, per);
		rng("crystal period", per, DEVICE_RESET_TIMER);
		rd_chk(A_CT, 8'h03, "ctrl kept");
		$display("watchdog sleep test done");
	endtask

	task automatic t_wake;
		int per;
		ev(3'h4);
		repeat (3) @(posedge aclk);
		chk("wake while awake", 8'h0, {7'h0, chip_reset});
		axi_wr(A_ST, 8'hE5, RCR_RESP_OKAY);
		ev(3'h1);
		@(posedge aclk);
		do_reset(3'h4, 8'h95, RCR_CAUSE_WAKE, 1'b1, per);
		$display("wake test done");
	endtask

	task automatic t_gpio;
		axi_wr(A_CT, 8'h00, RCR_RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk("pullup off", 8'h0, {7'h0, pin_pullup_en});
		shared_reset_port_pin <= 1'b0;
		repeat (8) @(posedge aclk);
		chk("no pin reset", 8'h0, {7'h0, chip_reset});
		chk("gpio low", 8'h0, {7'h0, gpio_level});
		shared_reset_port_pin <= 1'b1;
		repeat (6) @(posedge aclk);
		axi_wr(A_CT, 8'h01, RCR_RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk("pullup on", 8'h1, {7'h0, pin_pullup_en});
		$display("pin mode test done");
	endtask

	task automatic t_refused;
		logic [7:0] d;
		logic [1:0] r;
		axi_rd(32'h40, d, r);
		chk("unmapped data", 8'h0, d);
		chk("unmapped resp", {6'h0, RCR_RESP_SLVERR}, {6'h0, r});
		axi_wr(32'h40, 8'h55, RCR_RESP_SLVERR);
		axi_wr(A_CS, 8'h3F, RCR_RESP_SLVERR);
		rd_chk(A_CS, RCR_CAUSE_WAKE, "cause read-only");
		$display("refusal test done");
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Main sequence: power-on reset held for 16 cycles, then each cause in turn.
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_por();
		t_wdt_run();
		t_pin_run();
		t_sleep_pin();
		t_sleep_wdt();
		t_wake();
		t_gpio();
		t_refused();
		wrap_up();
	end

	// Run needs about 10000 cycles; the limit allows more than twice that.
	initial begin
		#3000000;
		mismatches++;
		$display("watchdog limit reached");
		wrap_up();
	end
endmodule
